/* File: src/lcis_pkg.sv */
package lcis_pkg;
  localparam int unsigned LINES = 4;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned SRC_N = 64;
  localparam int unsigned EN_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_SEL0 = 8'h00;
  localparam logic [7:0] OFS_SEL1 = 8'h04;
  localparam logic [7:0] OFS_SEL2 = 8'h08;
  localparam logic [7:0] OFS_SEL3 = 8'h0C;
  localparam logic [7:0] OFS_GATE_EN = 8'h10;
  localparam logic [7:0] OFS_POL = 8'h14;
  localparam int unsigned POL_BIT = 0;
  localparam int unsigned TRUE_POS = 1;
  localparam int unsigned INV_POS = 0;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage

/* File: src/lcis_cfg_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface lcis_cfg_if;
  logic [lcis_pkg::SEL_W-1:0] sel [lcis_pkg::LINES];
  logic [lcis_pkg::EN_W-1:0] en;
  logic pol;
  logic [lcis_pkg::SRC_N-1:0] src;
  logic [lcis_pkg::LINES-1:0] data;
  logic gate_out;
  modport regs (output sel, output en, output pol, input src, input data, input gate_out);
  modport mux (input sel, output src, output data);
  modport gate (input data, input en, input pol, output gate_out);
endinterface
`default_nettype wire

/* File: src/lcis_src_mux.sv */
`timescale 1ns/100ps
`default_nettype none
module lcis_src_mux #(
  parameter int unsigned SRC_N = lcis_pkg::SRC_N,
  parameter int unsigned LINES = lcis_pkg::LINES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [SRC_N-1:0] i_sources,
  lcis_cfg_if.mux cfg
);
  logic [SRC_N-1:0] meta;
  logic [SRC_N-1:0] synced;

  // Sources arrive from outside the clock domain and pass two flops first.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta <= '0;
      synced <= '0;
    end
    else
    begin
      meta <= i_sources;
      synced <= meta;
    end
  end

  assign cfg.src = synced;

  for (genvar g = 0; g < LINES; g++)
  begin : g_line
    assign cfg.data[g] = synced[cfg.sel[g]]; // [R1] [R2] [R3] [R4]
  end
endmodule // lcis_src_mux
`default_nettype wire

/* File: src/lcis_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module lcis_gate #(
  parameter int unsigned LINES = lcis_pkg::LINES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  lcis_cfg_if.gate cfg
);
  logic [LINES-1:0] term;
  logic raw;

  for (genvar g = 0; g < LINES; g++)
  begin : g_term
    assign term[g] = (cfg.en[2*g+lcis_pkg::TRUE_POS] & cfg.data[g])
      | (cfg.en[2*g+lcis_pkg::INV_POS] & ~cfg.data[g]); // [R7]
  end

  // The gate ORs every enabled form; with nothing enabled the OR is zero and the output equals the polarity bit.
  assign raw = |term;
  assign cfg.gate_out = raw ^ cfg.pol; // [R8]

  a_gate_none_on: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    (cfg.en == '0) |-> !cfg.gate_out == !cfg.pol)
    else $error("gate output not idle with all enables clear");

  a_gate_true_on: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    (cfg.en[lcis_pkg::TRUE_POS] && cfg.data[0]) |-> (cfg.gate_out != cfg.pol))
    else $error("enabled true line did not reach gate");

  a_gate_pol_flip: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
    ($changed(cfg.pol) && $stable(raw)) |-> (cfg.gate_out != $past(cfg.gate_out)))
    else $error("polarity change did not invert gate output");
endmodule // lcis_gate
`default_nettype wire

/* File: src/lcis_top.sv */
// How it works
// (R1) Selector one field routes source to line one.
// (R2) Selector two field routes source to line two.
// (R3) Selector three field routes source to line three.
// (R4) Selector four field routes source to line four.
// (R5) Selector bits 7-6 read zero, ignore writes.
// (R6) Config keeps contents across ordinary reset.
// (R7) True and inverted enables gate each line.
// (R8) Polarity bit inverts first gate output.
// (R9) New settings apply at write edge.
`timescale 1ns/100ps
`default_nettype none
module lcis_top #(
  parameter int unsigned SRC_N = lcis_pkg::SRC_N,
  parameter int unsigned LINES = lcis_pkg::LINES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [lcis_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [lcis_pkg::DATA_W-1:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [lcis_pkg::DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [SRC_N-1:0] I_SOURCES,
  output logic [LINES-1:0] O_DATA_LINE,
  output logic O_GATE_A
);
  lcis_cfg_if cfg ();

  logic [lcis_pkg::SEL_W-1:0] sel [LINES];
  logic [lcis_pkg::EN_W-1:0] gate_en;
  logic gate_a_output_invert;
  logic setup;
  logic access;
  logic wr;
  logic sel_hit;
  logic [1:0] sel_idx;
  logic hit;
  logic [lcis_pkg::DATA_W-1:0] next_rdata;

  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign wr = access && I_PWRITE && I_PSTRB[0];
  assign sel_hit = (I_PADDR[7:4] == 4'h0) && (I_PADDR[1:0] == 2'b00);
  assign sel_idx = I_PADDR[3:2];
  assign hit = sel_hit || (I_PADDR == lcis_pkg::OFS_GATE_EN)
    || (I_PADDR == lcis_pkg::OFS_POL);

  // Configuration storage has no reset term: it powers up unknown and rides
  // through the ordinary reset untouched.
  always_ff @(posedge I_CLK)
  begin
    for (int i = 0; i < LINES; i++)
    begin
      if (wr && sel_hit && (sel_idx == i[1:0]))
      begin
        sel[i] <= I_PWDATA[lcis_pkg::SEL_W-1:0]; // [R1] [R2] [R3] [R4] [R5] [R6] [R9]
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (wr && (I_PADDR == lcis_pkg::OFS_GATE_EN))
    begin
      gate_en <= I_PWDATA[lcis_pkg::EN_W-1:0]; // [R6] [R7] [R9]
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (wr && (I_PADDR == lcis_pkg::OFS_POL))
    begin
      gate_a_output_invert <= I_PWDATA[lcis_pkg::POL_BIT]; // [R6] [R8] [R9]
    end
  end

  for (genvar g = 0; g < LINES; g++)
  begin : g_cfg
    assign cfg.sel[g] = sel[g];
  end
  assign cfg.en = gate_en;
  assign cfg.pol = gate_a_output_invert;

  always_comb
  begin
    next_rdata = lcis_pkg::PRDATA_RST;
    if (sel_hit)
    begin
      next_rdata[lcis_pkg::SEL_W-1:0] = sel[sel_idx]; // [R5]
    end
    else if (I_PADDR == lcis_pkg::OFS_GATE_EN)
    begin
      next_rdata[lcis_pkg::EN_W-1:0] = gate_en;
    end
    else if (I_PADDR == lcis_pkg::OFS_POL)
    begin
      next_rdata[lcis_pkg::POL_BIT] = gate_a_output_invert;
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_PRDATA <= lcis_pkg::PRDATA_RST;
    end
    else if (setup && !I_PWRITE)
    begin
      O_PRDATA <= next_rdata;
    end
  end

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && !hit;

  lcis_src_mux #(
    .SRC_N(SRC_N),
    .LINES(LINES)
  ) u_mux (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_sources(I_SOURCES),
    .cfg(cfg.mux)
  );

  lcis_gate #(
    .LINES(LINES)
  ) u_gate (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .cfg(cfg.gate)
  );

  assign O_DATA_LINE = cfg.data;
  assign O_GATE_A = cfg.gate_out;

  sequence s_write(logic [7:0] ofs);
    access && I_PWRITE && I_PSTRB[0] && (I_PADDR == ofs);
  endsequence

  property p_route(logic [7:0] ofs, int idx);
    @(posedge I_CLK) disable iff (I_RST)
    s_write(ofs) |=> (sel[idx] == $past(I_PWDATA[5:0]))
      && (O_DATA_LINE[idx] == cfg.src[$past(I_PWDATA[5:0])]);
  endproperty

  a_line_one_route: assert property (p_route(lcis_pkg::OFS_SEL0, 0)) // [R1]
    else $error("line one not routed from written source");
  a_line_two_route: assert property (p_route(lcis_pkg::OFS_SEL1, 1)) // [R2]
    else $error("line two not routed from written source");
  a_line_three_route: assert property (p_route(lcis_pkg::OFS_SEL2, 2)) // [R3]
    else $error("line three not routed from written source");
  a_line_four_route: assert property (p_route(lcis_pkg::OFS_SEL3, 3)) // [R4]
    else $error("line four not routed from written source");

  a_sel_upper_zero: assert property (@(posedge I_CLK) disable iff (I_RST) // [R5]
    (setup && !I_PWRITE && sel_hit) ##1 access |-> (O_PRDATA[31:6] == 26'h0)
      && (O_PRDATA[5:0] == sel[$past(sel_idx)]))
    else $error("selector read shows upper bits or wrong field");

  // Storage may still be unknown from power-up, so identity is compared here.
  a_cfg_keep_reset: assert property (@(posedge I_CLK) // [R6]
    (I_RST && !access) |=> (gate_en === $past(gate_en))
      && (gate_a_output_invert === $past(gate_a_output_invert))
      && (sel[0] === $past(sel[0])) && (sel[3] === $past(sel[3])))
    else $error("configuration changed across reset");

  a_apply_write_now: assert property (@(posedge I_CLK) disable iff (I_RST) // [R9]
    s_write(lcis_pkg::OFS_GATE_EN) |=> (gate_en == $past(I_PWDATA[7:0]))
      && (cfg.en == gate_en))
    else $error("gate enables not applied at write edge");

  a_bus_unmapped: assert property (@(posedge I_CLK) disable iff (I_RST)
    (access && !hit) |-> O_PSLVERR && O_PREADY)
    else $error("unmapped access not flagged");

  // A read word is fixed in the setup cycle and shown in the access cycle
  // that follows it, so the read checks look one cycle past the setup.
  sequence s_read(logic [7:0] ofs);
    setup && !I_PWRITE && (I_PADDR == ofs) ##1 access;
  endsequence

  // A write that must leave every setting alone: the low lane is not
  // strobed, or the address maps to no register.
  sequence s_foreign_write;
    access && I_PWRITE && (!I_PSTRB[0] || !hit);
  endsequence

  // A selector only moves on a write to its own word; across resets and
  // other traffic it keeps whatever it held, known or not.
  property p_sel_hold(logic [7:0] ofs, int idx);
    @(posedge I_CLK)
    !(wr && (I_PADDR == ofs))
      |=> (sel[idx] === $past(sel[idx]));
  endproperty

  a_line_one_hold: assert property (p_sel_hold(lcis_pkg::OFS_SEL0, 0)) // [R1]
    else $error("line one selector moved without a write");
  a_line_two_hold: assert property (p_sel_hold(lcis_pkg::OFS_SEL1, 1)) // [R2]
    else $error("line two selector moved without a write");
  a_line_three_hold: assert property (p_sel_hold(lcis_pkg::OFS_SEL2, 2)) // [R3]
    else $error("line three selector moved without a write");
  a_line_four_hold: assert property (p_sel_hold(lcis_pkg::OFS_SEL3, 3)) // [R4]
    else $error("line four selector moved without a write");

  // Every selector word reads back its field with the two top bits at zero.
  property p_sel_read(logic [7:0] ofs, int idx);
    @(posedge I_CLK) disable iff (I_RST)
    s_read(ofs)
      |-> (O_PRDATA == {26'h000_0000, sel[idx]});
  endproperty

  a_line_one_read: assert property (p_sel_read(lcis_pkg::OFS_SEL0, 0)) // [R5]
    else $error("line one selector read back wrong");
  a_line_two_read: assert property (p_sel_read(lcis_pkg::OFS_SEL1, 1)) // [R5]
    else $error("line two selector read back wrong");
  a_line_three_read: assert property (p_sel_read(lcis_pkg::OFS_SEL2, 2)) // [R5]
    else $error("line three selector read back wrong");
  a_line_four_read: assert property (p_sel_read(lcis_pkg::OFS_SEL3, 3)) // [R5]
    else $error("line four selector read back wrong");

  // The polarity bit takes effect at the edge that ends its write.
  a_pol_apply_now: assert property (@(posedge I_CLK) disable iff (I_RST) // [R8] [R9]
    s_write(lcis_pkg::OFS_POL)
      |=> (gate_a_output_invert == $past(I_PWDATA[0])) && (cfg.pol == gate_a_output_invert))
    else $error("polarity not applied at write edge");

  a_en_read_back: assert property (@(posedge I_CLK) disable iff (I_RST) // [R7]
    s_read(lcis_pkg::OFS_GATE_EN) |-> (O_PRDATA == {24'h00_0000, gate_en}))
    else $error("gate enables read back wrong");

  a_pol_read_back: assert property (@(posedge I_CLK) disable iff (I_RST) // [R8]
    s_read(lcis_pkg::OFS_POL) |-> (O_PRDATA == {31'h0000_0000, gate_a_output_invert}))
    else $error("polarity read back wrong");

  a_unmapped_read_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    (setup && !I_PWRITE && !hit) ##1 access |-> (O_PRDATA == 32'h0000_0000))
    else $error("unmapped read not zero");

  // Writes that miss every register, or leave the low lane unstrobed, must
  // not disturb any setting.
  a_foreign_write_drop: assert property (@(posedge I_CLK) // [R6]
    s_foreign_write |=> (gate_en === $past(gate_en))
      && (gate_a_output_invert === $past(gate_a_output_invert))
      && (sel[1] === $past(sel[1])) && (sel[2] === $past(sel[2])))
    else $error("ignored write changed a setting");

  a_en_hold: assert property (@(posedge I_CLK) // [R7]
    !(wr && (I_PADDR == lcis_pkg::OFS_GATE_EN)) |=> (gate_en === $past(gate_en)))
    else $error("gate enables moved without a write");

  a_pol_hold: assert property (@(posedge I_CLK) // [R8]
    !(wr && (I_PADDR == lcis_pkg::OFS_POL))
      |=> (gate_a_output_invert === $past(gate_a_output_invert)))
    else $error("polarity moved without a write");

  a_mapped_no_err: assert property (@(posedge I_CLK) disable iff (I_RST)
    (access && hit) |-> !O_PSLVERR)
    else $error("error flagged on a mapped register");

  a_idle_no_err: assert property (@(posedge I_CLK) disable iff (I_RST)
    !access |-> !O_PSLVERR)
    else $error("error flagged outside an access phase");

  a_ready_always: assert property (@(posedge I_CLK) O_PREADY)
    else $error("ready dropped");

  // Read data stands until the next read setup replaces it.
  a_prdata_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    !(setup && !I_PWRITE) |=> $stable(O_PRDATA))
    else $error("read data changed without a read setup");

  a_rst_clears_sync: assert property (@(posedge I_CLK)
    I_RST |=> (cfg.src == '0) && (O_PRDATA == 32'h0000_0000))
    else $error("reset did not clear source flops and read data");
endmodule // lcis_top
`default_nettype wire

/* File: testbench/test_logic_cell_input_select.sv */
`timescale 1ns/100ps
`default_nettype none
module test_logic_cell_input_select;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [63:0] src = 64'h0000_0000_0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] dline;
  logic gate;
  logic [5:0] sel [4];
  logic [7:0] en;
  logic pol;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;

  lcis_top i_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SOURCES(src),
    .O_DATA_LINE(dline), .O_GATE_A(gate));

  always #10 I_CLK = ~I_CLK;

  always @(posedge I_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge I_CLK);
    pen <= 1'b1;
    @(posedge I_CLK);
    while (pready !== 1'b1) @(posedge I_CLK);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  function automatic logic [3:0] lines_exp();
    logic [3:0] l;
    for (int k = 0; k < 4; k++) l[k] = src[sel[k]];
    return l;
  endfunction

  function automatic logic gate_exp();
    logic [3:0] l;
    logic g;
    l = lines_exp();
    g = 1'b0;
    for (int k = 0; k < 4; k++) g = g | (en[2*k+1] & l[k]) | (en[2*k] & ~l[k]);
    return g ^ pol;
  endfunction

  task automatic set_sel(input int k, input logic [31:0] d);
    sel[k] = d[5:0];
    apb(1'b1, lcis_pkg::OFS_SEL0 + 8'(4*k), d);
    #1 chk(32'(dline[k]), 32'(src[sel[k]]));
    apb(1'b0, lcis_pkg::OFS_SEL0 + 8'(4*k), 32'h0000_0000);
    chk(r, {26'h000_0000, sel[k]});
  endtask

  task automatic settle();
    src <= {$urandom, $urandom};
    repeat (3) @(posedge I_CLK);
  endtask

  initial
  begin
    void'($urandom(32'hcc59));
    en = 8'h00;
    pol = 1'b0;
    repeat (8) @(posedge I_CLK);
    I_RST <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      settle();
      for (int k = 0; k < 4; k++)
        set_sel(k, i == 0 ? 32'h0000_00C0 : i == 1 ? 32'hFFFF_FFFF : $urandom);
    end
    $display("test 1 done");
    for (int i = 0; i < 24; i++)
    begin
      en = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom);
      pol = 1'($urandom);
      apb(1'b1, lcis_pkg::OFS_GATE_EN, {24'h00_0000, en});
      apb(1'b1, lcis_pkg::OFS_POL, {31'h0000_0000, pol});
      #1 chk(32'(gate), 32'(gate_exp()));
      apb(1'b0, lcis_pkg::OFS_GATE_EN, 32'h0000_0000);
      chk(r, {24'h00_0000, en});
      settle();
      #1 chk(32'(gate), 32'(gate_exp()));
    end
    $display("test 2 done");
    I_RST <= 1'b1;
    repeat (2) @(posedge I_CLK);
    I_RST <= 1'b0;
    repeat (3) @(posedge I_CLK);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, lcis_pkg::OFS_SEL0 + 8'(4*k), 32'h0000_0000);
      chk(r, {26'h000_0000, sel[k]});
    end
    chk(32'(dline), 32'(lines_exp()));
    chk(32'(gate), 32'(gate_exp()));
    $display("test 3 done");
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, lcis_pkg::OFS_SEL0, 32'h0000_0000);
    chk(r, {26'h000_0000, sel[0]});
    chk(32'(e), 32'h0000_0000);
    $display("test 4 done");
    tally_and_finish();
  end
endmodule // test_logic_cell_input_select
`default_nettype wire
